/* hw/crms_pkg.sv */
// How it works
// - Precise rms path runs only in full power; mean-absolute path runs in both modes.
// - Precise path squares each sample, low-pass filters it, then takes a square root.
// - Precise rms runs together on three phase currents, neutral and three voltages, 24 bits.
// - Mean-absolute estimate runs together on the three phase currents only, 20 bits.
// - Current rms results are signed 24-bit values refreshed at 8 kHz.
// - Full-scale sine reads 0x3ff6a6 with integrator off, at any line frequency.
// - Integrator on: full scale reads 0x3ff6a6 at 50 Hz and 0x354d8a at 60 Hz.
// - Current rms settles within 530 ms off, 550 ms or 500 ms on.
// - Current rms reads as a 32-bit word with the upper 8 bits zero.
// - A signed 24-bit per-channel offset is added to the raw current rms.
// - Offset words have upper 4 bits zero, value sign extended to 28 bits.
// - Mean-absolute path high-passes, rectifies and low-passes; unsigned 20 bits at 8 kHz.
// - Full-scale sine gives mean-absolute 209686 at 50 Hz and 210921 at 60 Hz.
// - Mean-absolute result is within 0.5 percent of final value within 500 ms.
// - Mean-absolute reads as a 32-bit word with the upper 12 bits zero.
// - No mean-absolute result exists for the neutral current.
package crms_pkg;
    localparam int CLK_HZ = 250000000;
    localparam int UPDATE_HZ = 8000;
    localparam int UPDATE_DIV = CLK_HZ / UPDATE_HZ;
    localparam int NUM_RMS = 7;
    localparam int NUM_CUR = 4;
    localparam int NUM_MAV = 3;
    localparam int SAMPLE_W = 24;
    localparam int RMS_W = 24;
    localparam int MAV_W = 20;
    localparam int DSP_W = 28;
    localparam int ACC_W = 48;
    // Filter shifts: time constant of 2**k update periods.
    localparam int LPF_SHIFT = 9;
    localparam int HPF_SHIFT = 10;
    localparam logic [11:0] ADDR_IRMS0 = 12'h000;
    localparam logic [11:0] ADDR_VRMS0 = 12'h010;
    localparam logic [11:0] ADDR_OFS0 = 12'h020;
    localparam logic [11:0] ADDR_MAV0 = 12'h030;
    localparam logic [11:0] ADDR_CONFIG = 12'h040;
    localparam int CFG_INTEGRATOR_ENABLE_BIT = 0;
    localparam int CFG_FULLPWR_BIT = 1;
    localparam logic [1:0] CFG_RESET = 2'h2;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [2:0] HSIZE_WORD = 3'h2;

    typedef struct packed {
        logic [SAMPLE_W-1:0] ia;
        logic [SAMPLE_W-1:0] ib;
        logic [SAMPLE_W-1:0] ic;
        logic [SAMPLE_W-1:0] in;
        logic [SAMPLE_W-1:0] va;
        logic [SAMPLE_W-1:0] vb;
        logic [SAMPLE_W-1:0] vc;
    } crms_samples_t;

    typedef enum logic [1:0] {
        CRMS_IDLE,
        CRMS_FILT,
        CRMS_SQRT,
        CRMS_DONE
    } crms_state_t;
endpackage : crms_pkg

/* hw/crms_top.sv */
`timescale 1ns/1ps
// Rms and mean-absolute measurement with an AHB-Lite register slave.
// Seven signed sample channels arrive on the system clock, one value each.
// A divider makes one tick per result period; every filter steps only on it.
// The precise path squares, smooths and then takes a bit-serial square root.
// The root is shared by all seven channels, one bit per clock cycle.
// Sharing one root engine costs about 170 cycles per period but saves area.
// The mean-absolute path high-passes, rectifies and smooths the three phases.
// It keeps running in reduced power, where the precise path holds still.
// Offset trims are added to the four current results before they are published.
// The rms words change together on one clock edge, once per period; the mean-absolute words follow one cycle later.
// A host that reads the rms words between two publishes therefore never sees mixed periods.
// The filter time constants are fixed shifts and are not calibrated.
// Full-scale readings and settling times are therefore only approximate.
// The slave never inserts wait states and always answers OKAY.
// Read data is registered, so it appears in the data phase of the read.
// Writes land at the end of their data phase, one cycle after the address.
// Addresses that map to nothing read as zero and ignore writes.
// The divider must leave room for the root engine: at least 180 cycles.
module crms_top #(
    parameter int UPDATE_DIV = crms_pkg::UPDATE_DIV
) (
    input wire logic hclk, // System clock.
    input wire logic hresetn, // Asynchronous reset, active low.
    input wire logic hsel, // Slave select.
    input wire logic [31:0] haddr, // Byte address.
    input wire logic [1:0] htrans, // Transfer type.
    input wire logic hwrite, // Write when high.
    input wire logic [2:0] hsize, // Transfer size.
    input wire logic hready, // Bus ready in.
    input wire logic [31:0] hwdata, // Write data.
    output logic [31:0] hrdata, // Read data.
    output logic hreadyout, // Slave ready.
    output logic hresp, // Always OKAY.
    input wire crms_pkg::crms_samples_t samples, // Signed ADC samples, same clock.
    output logic update_pulse // One cycle at each 8 kHz result update.
);
    localparam int SW = crms_pkg::SAMPLE_W;
    localparam int AW = crms_pkg::ACC_W;
    localparam int NR = crms_pkg::NUM_RMS;
    localparam int NC = crms_pkg::NUM_CUR;
    localparam int NM = crms_pkg::NUM_MAV;

    // Scale a mean-absolute accumulator down to the 20-bit result.
    // Saturation keeps a large input from wrapping to a small reading.
    function automatic logic [crms_pkg::MAV_W-1:0] mav_clip(input logic signed [AW-1:0] m);
        logic signed [AW-1:0] s;
        s = m >>> crms_pkg::HPF_SHIFT;
        if (s < 0) mav_clip = '0;
        else if (s > AW'({crms_pkg::MAV_W{1'b1}})) mav_clip = '1;
        else mav_clip = s[crms_pkg::MAV_W-1:0];
    endfunction : mav_clip

    // Pick one channel out of the packed sample bundle, channel 0 first.
    function automatic logic signed [SW-1:0] chan(input crms_pkg::crms_samples_t s,
                                                  input int i);
        logic [SW*NR-1:0] flat;
        flat = s;
        chan = flat[SW*(NR-1-i) +: SW];
    endfunction : chan

    // Decode a register index from a word address within a bank of four.
    function automatic logic [1:0] word_idx(input logic [11:0] a);
        word_idx = a[3:2];
    endfunction : word_idx


    // Update-rate divider; the tick starts one computation round.
    // A one-cycle enable keeps the whole block on the single system clock.
    // The count is wide enough for any sensible clock to rate ratio.
    logic [31:0] div_q, div_d;
    logic tick;
    always_comb begin
        tick = (div_q == 32'(UPDATE_DIV - 1));
        div_d = tick ? 32'h0 : div_q + 32'h1;
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) div_q <= 32'h0;
        else div_q <= div_d;
    end


    // Configuration: integrator enable and power mode.
    // Both bits take effect at the next tick; a round in flight completes.
    // Trims are held signed so the addition below needs no extra sign logic.
    logic [1:0] cfg_q, cfg_d;
    logic signed [SW-1:0] ofs_q [NC];
    logic signed [SW-1:0] ofs_d [NC];
    logic full_power;
    assign full_power = cfg_q[crms_pkg::CFG_FULLPWR_BIT];


    // Integrator on current channels: leaky accumulator flattens di/dt sensor response.
    // The leak stops a dc offset on the input from growing without bound.
    // Its gain is the leak shift, which is taken back out before squaring.
    logic signed [AW-1:0] integ_q [NC];
    logic signed [AW-1:0] integ_d [NC];
    // Square smoothing filter state for the precise path.
    logic signed [AW-1:0] sq_q [NR];
    logic signed [AW-1:0] sq_d [NR];
    // High-pass state and rectified smoothing for the mean-absolute path.
    logic signed [AW-1:0] hp_q [NM];
    logic signed [AW-1:0] hp_d [NM];
    logic signed [AW-1:0] mav_q [NM];
    logic signed [AW-1:0] mav_d [NM];


    // One filter slice per channel; only the current slices see the integrator.
    // The square is scaled down at once so the smoothing state cannot overflow.
    // A negative smoothed square can only come from a transient and is treated as zero.
    genvar g;
    generate
        for (g = 0; g < NR; g++) begin : g_rms
            logic signed [SW-1:0] x;
            logic signed [AW-1:0] xs;
            logic signed [AW-1:0] sq;
            always_comb begin
                x = chan(samples, g);
                if (g < NC && cfg_q[crms_pkg::CFG_INTEGRATOR_ENABLE_BIT])
                    xs = integ_q[g >= NC ? 0 : g] >>> crms_pkg::LPF_SHIFT;
                else
                    xs = AW'(x);
                sq = (xs * xs) >>> SW;
                // Precise path only advances in full power; else it holds.
                if (tick && full_power)
                    sq_d[g] = sq_q[g] + ((sq - sq_q[g]) >>> crms_pkg::LPF_SHIFT);
                else
                    sq_d[g] = sq_q[g];
            end
            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) sq_q[g] <= '0;
                else sq_q[g] <= sq_d[g];
            end
        end
        for (g = 0; g < NC; g++) begin : g_int
            always_comb begin
                if (tick)
                    integ_d[g] = integ_q[g] + AW'(chan(samples, g))
                                 - (integ_q[g] >>> crms_pkg::LPF_SHIFT);
                else
                    integ_d[g] = integ_q[g];
            end
            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) integ_q[g] <= '0;
                else integ_q[g] <= integ_d[g];
            end
        end
        for (g = 0; g < NM; g++) begin : g_mav
            logic signed [AW-1:0] x;
            logic signed [AW-1:0] hpo;
            logic signed [AW-1:0] ab;
            always_comb begin
                x = AW'(chan(samples, g)) <<< crms_pkg::HPF_SHIFT;
                hpo = x - hp_q[g];
                ab = hpo[AW-1] ? -hpo : hpo;
                // Runs in both power modes; neutral has no instance.
                if (tick) begin
                    hp_d[g] = hp_q[g] + (hpo >>> crms_pkg::HPF_SHIFT);
                    mav_d[g] = mav_q[g] + ((ab - mav_q[g]) >>> crms_pkg::LPF_SHIFT);
                end else begin
                    hp_d[g] = hp_q[g];
                    mav_d[g] = mav_q[g];
                end
            end
            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    hp_q[g] <= '0;
                    mav_q[g] <= '0;
                end else begin
                    hp_q[g] <= hp_d[g];
                    mav_q[g] <= mav_d[g];
                end
            end
        end
    endgenerate


    // Sequencer: a bit-serial square root per channel, then an atomic publish.
    // The root is built from the top bit down, one trial per cycle.
    // Raw roots are parked until the last channel is done, so nothing is shown early.
    // In reduced power the root is skipped and only the mean-absolute words move.
    crms_pkg::crms_state_t st_q, st_d;
    logic [2:0] ch_q, ch_d;
    logic [4:0] bit_q, bit_d;
    logic [SW-1:0] root_q, root_d;
    logic [SW-1:0] raw_q [NR];
    logic [SW-1:0] raw_d [NR];
    logic [SW-1:0] pub_rms_q [NR];
    logic [SW-1:0] pub_rms_d [NR];
    logic [crms_pkg::MAV_W-1:0] pub_mav_q [NM];
    logic [crms_pkg::MAV_W-1:0] pub_mav_d [NM];
    logic upd_q, upd_d;
    always_comb begin
        logic [SW-1:0] trial;
        logic [AW-1:0] tsq;
        logic [AW-1:0] val;
        logic signed [SW+1:0] sum;
        trial = '0;
        tsq = '0;
        val = '0;
        sum = '0;
        st_d = st_q;
        ch_d = ch_q;
        bit_d = bit_q;
        root_d = root_q;
        upd_d = 1'b0;
        for (int i = 0; i < NR; i++) begin
            raw_d[i] = raw_q[i];
            pub_rms_d[i] = pub_rms_q[i];
        end
        for (int i = 0; i < NM; i++) pub_mav_d[i] = pub_mav_q[i];
        case (st_q)
            crms_pkg::CRMS_IDLE: begin
                if (tick) begin
                    st_d = full_power ? crms_pkg::CRMS_SQRT : crms_pkg::CRMS_DONE;
                    ch_d = 3'h0;
                    bit_d = 5'(SW - 1);
                    root_d = '0;
                end
            end
            crms_pkg::CRMS_SQRT: begin
                val = sq_q[ch_q][AW-1] ? '0 : sq_q[ch_q];
                trial = root_q | (SW'(1) << bit_q);
                tsq = AW'(trial) * AW'(trial);
                if (tsq <= (val << SW)) root_d = trial;
                if (bit_q == 5'h0) begin
                    raw_d[ch_q] = (tsq <= (val << SW)) ? trial : root_q;
                    root_d = '0;
                    bit_d = 5'(SW - 1);
                    if (ch_q == 3'(NR - 1)) st_d = crms_pkg::CRMS_FILT;
                    else ch_d = ch_q + 3'h1;
                end else begin
                    bit_d = bit_q - 5'h1;
                end
            end
            crms_pkg::CRMS_FILT: begin
                // Offset trim on the four currents, clipped to the range zero to 0x7fffff.
                // Clipping at zero hides a trim that overshoots the noise floor.
                // The voltage words pass through with no trim of their own here.
                for (int i = 0; i < NR; i++) begin
                    if (i < NC)
                        sum = $signed({2'b00, raw_q[i]}) + 26'(ofs_q[i >= NC ? 0 : i]);
                    else
                        sum = $signed({2'b00, raw_q[i]});
                    if (sum < 0) pub_rms_d[i] = '0;
                    else if (sum > 26'sh7fffff) pub_rms_d[i] = 24'h7fffff;
                    else pub_rms_d[i] = sum[SW-1:0];
                end
                st_d = crms_pkg::CRMS_DONE;
            end
            crms_pkg::CRMS_DONE: begin
                for (int i = 0; i < NM; i++)
                    pub_mav_d[i] = mav_clip(mav_q[i]);
                upd_d = 1'b1;
                st_d = crms_pkg::CRMS_IDLE;
            end
            default: st_d = crms_pkg::CRMS_IDLE;
        endcase
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_q <= crms_pkg::CRMS_IDLE;
            ch_q <= 3'h0;
            bit_q <= 5'h0;
            root_q <= '0;
            upd_q <= 1'b0;
            for (int i = 0; i < NR; i++) begin
                raw_q[i] <= '0;
                pub_rms_q[i] <= '0;
            end
            for (int i = 0; i < NM; i++) pub_mav_q[i] <= '0;
        end else begin
            st_q <= st_d;
            ch_q <= ch_d;
            bit_q <= bit_d;
            root_q <= root_d;
            upd_q <= upd_d;
            for (int i = 0; i < NR; i++) begin
                raw_q[i] <= raw_d[i];
                pub_rms_q[i] <= pub_rms_d[i];
            end
            for (int i = 0; i < NM; i++) pub_mav_q[i] <= pub_mav_d[i];
        end
    end


    // AHB-Lite slave: zero-wait, address latched, write in data phase.
    // Read data is chosen in the address phase and registered into the data phase.
    // Write data is only valid in the data phase, hence the latched address.
    // The transfer size is not decoded; every register is one whole word.
    // Only the low twelve address bits are decoded, so the map repeats above.
    logic wr_q, wr_d;
    logic [11:0] wa_q, wa_d;
    logic [31:0] rd_q, rd_d;
    always_comb begin
        logic [11:0] a;
        logic act;
        a = haddr[11:0];
        act = hsel && hready && htrans == crms_pkg::HTRANS_NONSEQ;
        wr_d = act && hwrite;
        wa_d = a;
        cfg_d = cfg_q;
        for (int i = 0; i < NC; i++) ofs_d[i] = ofs_q[i];
        if (wr_q) begin
            if (wa_q[11:4] == crms_pkg::ADDR_OFS0[11:4])
                ofs_d[word_idx(wa_q)] = hwdata[SW-1:0];
            else if (wa_q == crms_pkg::ADDR_CONFIG)
                cfg_d = hwdata[1:0];
        end
        rd_d = rd_q;
        if (act && !hwrite) begin
            rd_d = 32'h0;
            if (a[11:4] == crms_pkg::ADDR_IRMS0[11:4])
                rd_d = {8'h00, pub_rms_q[word_idx(a)]};
            else if (a[11:4] == crms_pkg::ADDR_VRMS0[11:4] && word_idx(a) != 2'h3)
                rd_d = {8'h00, pub_rms_q[NC + word_idx(a)]};
            else if (a[11:4] == crms_pkg::ADDR_OFS0[11:4])
                rd_d = {4'h0, {4{ofs_q[word_idx(a)][SW-1]}}, ofs_q[word_idx(a)]};
            else if (a[11:4] == crms_pkg::ADDR_MAV0[11:4] && word_idx(a) != 2'h3)
                rd_d = {12'h000, pub_mav_q[word_idx(a)]};
            else if (a == crms_pkg::ADDR_CONFIG)
                rd_d = {30'h0, cfg_q};
        end
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_q <= 1'b0;
            wa_q <= 12'h000;
            rd_q <= 32'h0;
            cfg_q <= crms_pkg::CFG_RESET;
            for (int i = 0; i < NC; i++) ofs_q[i] <= '0;
        end else begin
            wr_q <= wr_d;
            wa_q <= wa_d;
            rd_q <= rd_d;
            cfg_q <= cfg_d;
            for (int i = 0; i < NC; i++) ofs_q[i] <= ofs_d[i];
        end
    end


    // Outputs come straight from registers; the slave never waits.
    // Ready and response are tied because no access can ever fail or stall.
    assign hrdata = rd_q;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign update_pulse = upd_q;
endmodule : crms_top

/* dv/crms_adc_model.sv */
`timescale 1ns/1ps
// Stand-in for the sample paths: a square wave on all seven channels.
module crms_adc_model (
    input wire logic hclk, // Clock.
    input wire logic hresetn, // Reset, active low.
    input wire logic [23:0] amp, // Peak code; zero gives silence.
    output crms_pkg::crms_samples_t samples // Samples into the block.
);
    logic [9:0] ph_d;
    logic [9:0] ph_q;
    // A square wave keeps rms and mean absolute value equal, so either path can be judged.
    always_comb begin
        ph_d = ph_q + 10'h001;
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ph_q <= 10'h000;
        end else begin
            ph_q <= ph_d;
        end
    end
    assign samples = ph_q[9] ? {7{24'h000000 - amp}} : {7{amp}};
endmodule : crms_adc_model

/* dv/crms_chk_sva.sv */
`timescale 1ns/1ps
// Watches read formats and publish timing at the top ports.
module crms_chk #(
    parameter int UPDATE_DIV = 256
) (
    input wire logic hclk, // Clock.
    input wire logic hresetn, // Reset, active low.
    input wire logic hsel, // Select.
    input wire logic [31:0] haddr, // Address.
    input wire logic [1:0] htrans, // Transfer type.
    input wire logic hwrite, // Write.
    input wire logic hready, // Bus ready.
    input wire logic [31:0] hrdata, // Read data.
    input wire logic hreadyout, // Slave ready.
    input wire logic hresp, // Response.
    input wire logic update_pulse // Publish strobe.
);
    logic take;
    logic rd_d;
    logic rd_q;
    logic [11:0] a_d;
    logic [11:0] a_q;
    logic [15:0] n_d;
    logic [15:0] n_q;
    // Track which register the data phase returns, and the time since the last publish.
    always_comb begin
        take = hsel && hready && htrans == crms_pkg::HTRANS_NONSEQ;
        rd_d = take && !hwrite;
        a_d = take ? haddr[11:0] : a_q;
        n_d = update_pulse ? 16'h0000 : ((n_q == 16'hffff) ? n_q : n_q + 16'h0001);
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rd_q <= 1'b0;
            a_q <= 12'h000;
            n_q <= 16'h0000;
        end else begin
            rd_q <= rd_d;
            a_q <= a_d;
            n_q <= n_d;
        end
    end
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    a_zero_wait: assert property (hreadyout && !hresp)
        else $error("wait state or error reply");
    a_irms_pad: assert property (rd_q && a_q < 12'h010 |-> hrdata[31:23] == 9'h000)
        else $error("current rms word badly padded");
    a_vrms_pad: assert property (rd_q && a_q inside {[12'h010:12'h018]} |-> hrdata[31:24] == 8'h00)
        else $error("voltage rms word badly padded");
    a_trim_ext: assert property (rd_q && a_q inside {[12'h020:12'h02c]} |->
        hrdata[31:28] == 4'h0 && hrdata[27:24] == {4{hrdata[23]}})
        else $error("trim word not sign extended");
    a_mav_pad: assert property (rd_q && a_q inside {[12'h030:12'h038]} |-> hrdata[31:20] == 12'h000)
        else $error("mean absolute word badly padded");
    a_no_neutral: assert property (rd_q && (a_q == 12'h03c || a_q > 12'h040) |-> hrdata == 32'h0)
        else $error("unmapped or neutral mean absolute not zero");
    a_data_holds: assert property (!(take && !hwrite) |=> $stable(hrdata))
        else $error("read data moved without a read");
    a_pulse_single: assert property (update_pulse |=> !update_pulse [*8])
        else $error("publish strobe too long or too close");
    a_update_rate: assert property (n_q < 2 * UPDATE_DIV + 200)
        else $error("results not refreshed in time");
    c_pulse: cover property (update_pulse);
    c_neg_trim: cover property (rd_q && a_q == 12'h020 && hrdata[23]);
    c_irms_live: cover property (rd_q && a_q == 12'h000 && hrdata != 32'h0);
endmodule : crms_chk

bind crms_top crms_chk #(.UPDATE_DIV(UPDATE_DIV)) u_chk (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .update_pulse(update_pulse));

/* dv/test_current_rms_mav_measurement.sv */
`timescale 1ns/1ps
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin bad_count++; \
    $display("ERROR %0t got %h exp %h", $time, a, e); end end
module test_current_rms_mav_measurement;
    localparam int DIV = 256;
    logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, update_pulse;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [23:0] amp, v;
    logic [23:0] tv [4];
    crms_pkg::crms_samples_t samples;
    int bad_count, compares, seed;
    crms_top #(.UPDATE_DIV(DIV)) u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout),
        .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .samples(samples), .update_pulse(update_pulse));
    crms_adc_model u_adc (.hclk(hclk), .hresetn(hresetn), .amp(amp), .samples(samples));
    initial begin
        hclk = 1'b0;
        forever #2 hclk = ~hclk;
    end
    // One single transfer; holds each phase until ready is seen high.
    task bus(input logic wr, input logic [31:0] a, input logic [31:0] wd);
        @(posedge hclk);
        htrans <= crms_pkg::HTRANS_NONSEQ;
        haddr <= a;
        hwrite <= wr;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask : bus
    // Waits for n publishes, each within a bounded span.
    task upd(input int n);
        int k;
        repeat (n) begin
            k = 0;
            do begin @(posedge hclk); k++; end while (update_pulse !== 1'b1 && k < 4 * DIV);
            `CHK(update_pulse, 1'b1)
        end
    endtask : upd
    function logic [31:0] trim_word(input logic [23:0] x);
        return {4'h0, {4{x[23]}}, x};
    endfunction : trim_word
    // Silent input: rms is the trim alone, negative results clip to zero.
    function logic [31:0] irms_exp(input logic [23:0] x);
        return x[23] ? 32'h0 : {8'h00, x};
    endfunction : irms_exp
    task end_of_test();
        $display("compares=%0d bad_count=%0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : end_of_test
    initial begin
        #80000;
        bad_count++;
        end_of_test();
    end
    initial begin
        seed = 32'h0ed04f05;
        bad_count = 0;
        compares = 0;
        {hresetn, hwrite, haddr, htrans, hwdata, amp} = '0;
        hsel = 1'b1;
        hsize = crms_pkg::HSIZE_WORD;
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        bus(1'b0, 32'h040, 32'h0);
        `CHK(rd, {30'h0, crms_pkg::CFG_RESET})
        bus(1'b0, 32'h020, 32'h0);
        `CHK(rd, 32'h0)
        // Random trims plus the most negative code, read back sign extended.
        for (int i = 0; i < 4; i++) begin
            tv[i] = (i == 3) ? 24'h800000 : 24'($random(seed));
            bus(1'b1, 32'(32'h020 + 4 * i), trim_word(tv[i]));
            bus(1'b0, 32'(32'h020 + 4 * i), 32'h0);
            `CHK(rd, trim_word(tv[i]))
        end
        $display("trim test done");
        upd(2);
        for (int i = 0; i < 4; i++) begin
            bus(1'b0, 32'(4 * i), 32'h0);
            `CHK(rd, irms_exp(tv[i]))
        end
        for (int i = 0; i < 5; i++) begin
            bus(1'b0, 32'(32'h030 + 4 * i), 32'h0);
            `CHK(rd, i == 4 ? 32'h2 : 32'h0)
        end
        // Read-only and unmapped places ignore writes.
        bus(1'b1, 32'h000, 32'h00123456);
        bus(1'b1, 32'h100, 32'hffffffff);
        bus(1'b0, 32'h100, 32'h0);
        `CHK(rd, 32'h0)
        bus(1'b0, 32'h000, 32'h0);
        `CHK(rd, irms_exp(tv[0]))
        $display("offset test done");
        // Reduced power freezes rms; full power resumes it.
        bus(1'b1, 32'h040, 32'h0);
        bus(1'b1, 32'h020, trim_word(24'h000100));
        upd(2);
        bus(1'b0, 32'h000, 32'h0);
        `CHK(rd, irms_exp(tv[0]))
        bus(1'b1, 32'h040, 32'h2);
        upd(2);
        bus(1'b0, 32'h000, 32'h0);
        `CHK(rd, 32'h100)
        $display("power mode test done");
        // Live input at a random positive amplitude.
        bus(1'b1, 32'h020, 32'h0);
        amp <= {2'b01, 22'($random(seed))};
        upd(8);
        bus(1'b0, 32'h000, 32'h0);
        `CHK(rd[31:23], 9'h000)
        `CHK(rd != 32'h0, 1'b1)
        // Raw reading only: gain and offset for this word belong to the host.
        bus(1'b0, 32'h030, 32'h0);
        `CHK(rd[31:20], 12'h000)
        `CHK(rd != 32'h0, 1'b1)
        bus(1'b0, 32'h03c, 32'h0);
        `CHK(rd, 32'h0)
        $display("live input test done");
        end_of_test();
    end
endmodule : test_current_rms_mav_measurement
